/* adec_consts.vh */
// Purpose: Opcode patterns and field positions for the arithmetic/aux decoder
// Assumes: 16-bit instruction words, one word per valid strobe
// Notes: Definitions only
`ifndef ADEC_CONSTS_VH
`define ADEC_CONSTS_VH
// ==========================================================
// Opcode classes (upper byte unless noted)
`define ADEC_OP_SUB_TSHIFT 8'h46
`define ADEC_OP_XOR_MEM 8'h4C
`define ADEC_OP_CLR_LD_HI 8'h40
`define ADEC_OP_CLR_LD_LO 8'h41
`define ADEC_OP_CLR_LD_RND 8'h7B
`define ADEC_OP_AUX_ADD 8'h7E
`define ADEC_OP_AUX_SUB 8'h7F
`define ADEC_OP_PAGE_MEM 8'h52
`define ADEC_OP_AUX_MOD 8'h55
`define ADEC_OP_PROD_HI_LD 8'h53
`define ADEC_OP_PROD_HI_ST 8'h7D
`define ADEC_OP_PROD_LO_ST 8'h7C
`define ADEC_OP_TLOAD 8'h3C
`define ADEC_OP_TLOAD_ADD 8'h3D
`define ADEC_OP_TLOAD_MOVE 8'h3F
`define ADEC_OP_TLOAD_COPY 8'h3E
`define ADEC_OP_TLOAD_SUB 8'h5B
`define ADEC_OP_MUL 8'h38
`define ADEC_OP_MUL_ADD 8'h3A
`define ADEC_OP_MUL_SUB 8'h3B
`define ADEC_OP_MUL_UNS 8'hCF
`define ADEC_OP_MAC 8'h5D
`define ADEC_OP_MAC_MOVE 8'h5C
`define ADEC_OP_SQR_ADD 8'h39
`define ADEC_OP_SQR_SUB 8'h5A
// Full words and partial patterns
`define ADEC_W_CLR_ACC 16'hCA00
`define ADEC_W_ADD_PROD 16'hCE15
`define ADEC_W_COPY_PROD 16'hCE14
`define ADEC_W_SUB_PROD 16'hCE16
`define ADEC_P_CMP_HI14 14'h3394
`define ADEC_P_PSHIFT_HI14 14'h3382
`define ADEC_P_ARP_HI13 13'h0AB1
`define ADEC_P_PAGE_IMM_HI7 7'h64
`define ADEC_P_MUL_IMM_HI3 3'h5
`define ADEC_P_XOR_IMM_HI4 4'hD
`define ADEC_P_XOR_IMM_LO 8'h06
`define ADEC_P_AUX_LONG_LO 8'h00
`define ADEC_N_AUX_LD_MEM 4'h3
`define ADEC_N_AUX_STORE 4'h7
`define ADEC_N_AUX_LD_IMM 4'hC
`define ADEC_N_AUX_LD_LONG 4'hD
// Operation codes driven to the datapath
`define ADEC_OPW 6
`define ADEC_NOP 6'h00
`define ADEC_SUB_TSHIFT 6'h01
`define ADEC_XOR_MEM 6'h02
`define ADEC_XOR_IMM 6'h03
`define ADEC_CLR_ACC 6'h04
`define ADEC_CLR_LD_HI 6'h05
`define ADEC_CLR_LD_LO 6'h06
`define ADEC_CLR_LD_RND 6'h07
`define ADEC_AUX_ADD 6'h08
`define ADEC_AUX_SUB 6'h09
`define ADEC_AUX_CMP 6'h0A
`define ADEC_AUX_LD_MEM 6'h0B
`define ADEC_AUX_STORE 6'h0C
`define ADEC_AUX_LD_IMM 6'h0D
`define ADEC_AUX_LD_LONG 6'h0E
`define ADEC_AUX_PTR_LD 6'h0F
`define ADEC_PAGE_LD_MEM 6'h10
`define ADEC_PAGE_LD_IMM 6'h11
`define ADEC_PROD_ADD 6'h12
`define ADEC_PROD_COPY 6'h13
`define ADEC_PROD_SUB 6'h14
`define ADEC_TLOAD 6'h15
`define ADEC_TLOAD_ADD 6'h16
`define ADEC_TLOAD_MOVE 6'h17
`define ADEC_TLOAD_COPY 6'h18
`define ADEC_TLOAD_SUB 6'h19
`define ADEC_MUL 6'h1A
`define ADEC_MUL_ADD 6'h1B
`define ADEC_MUL_SUB 6'h1C
`define ADEC_MUL_UNS 6'h1D
`define ADEC_MUL_IMM 6'h1E
`define ADEC_MAC 6'h1F
`define ADEC_MAC_MOVE 6'h20
`define ADEC_SQR_ADD 6'h21
`define ADEC_SQR_SUB 6'h22
`define ADEC_SHIFT_MODE 6'h23
`define ADEC_PROD_HI_LD 6'h24
`define ADEC_PROD_HI_ST 6'h25
`define ADEC_PROD_LO_ST 6'h26
`define ADEC_AUX_MODIFY 6'h27
`define ADEC_ILLEGAL 6'h3F
// Decoder states
`define ADEC_ST_FIRST 1'b0
`define ADEC_ST_SECOND 1'b1
`endif

/* adec_decoder.v */
// Purpose: Decode arithmetic, aux/page and multiply instruction words
// Assumes: One instruction word offered per cycle with word_valid_i
// Notes: Two-word forms hold the first word until the operand arrives
//
// Behaviour
// - Subtract memory shifted by multiplicand count
// - XOR memory, or shifted immediate two-word
// - Clear accumulator, clear-load high or low
// - Clear-load high half with rounding
// - Add or subtract short immediate aux
// - Compare current aux with aux zero
// - Aux load, store, short, long transfers
// - Load aux pointer from bits 2:0
// - Load page pointer from memory/immediate
// - Add, copy, subtract product to accumulator
// - Multiplicand loads with product side actions
// - Multiply variants, including 13-bit immediate
// - Two-word multiply-accumulate, optional data move
// - Square with add or subtract previous
// - Set 2-bit product shift mode
// - Product high load, high/low store
// - Aux modify only via indirect addressing
// - Aux field is 3 bits, eight registers
`timescale 1ns/1ps
`include "adec_consts.vh"

// ==========================================================
// Operation codes on op_code_o
// 00 idle after reset, never decoded
// 01 subtract memory shifted by multiplicand count
// 02 exclusive-OR memory word
// 03 exclusive-OR shifted immediate, two words
// 04 clear accumulator
// 05 clear low half, load high half
// 06 clear, load low half unsigned
// 07 clear low, load high, round
// 08 add short immediate to current aux
// 09 subtract short immediate from current aux
// 0A compare current aux with aux zero
// 0B aux load from memory
// 0C aux store to memory
// 0D aux load short immediate
// 0E aux load long immediate, two words
// 0F aux pointer load
// 10 page pointer load from memory
// 11 page pointer load immediate
// 12 add product to accumulator
// 13 copy product to accumulator
// 14 subtract product from accumulator
// 15 multiplicand load only
// 16 multiplicand load, add previous product
// 17 multiplicand load, add, move word up
// 18 multiplicand load, product to accumulator
// 19 multiplicand load, subtract previous
// 1A multiply by memory word
// 1B multiply, add previous product
// 1C multiply, subtract previous product
// 1D multiply unsigned
// 1E multiply by 13-bit immediate
// 1F multiply-accumulate, program operand
// 20 multiply-accumulate with data move
// 21 square, add previous product
// 22 square, subtract previous product
// 23 product shift mode set
// 24 product high half load
// 25 product high half store
// 26 product low half store
// 27 aux modify only
// 3F word not in these groups

// ==========================================================
// Field use by output
// Indirect_o: bit 7 of a memory-reference word
// Direct_off_o: bits 6:0, page offset
// Ind_ctrl_o: bits 7:0, passed on raw
// Aux_sel_o: bits 10:8, one of eight
// Cond_o: bits 1:0, compare code or mode
// Shift_o: bits 11:8, immediate shift
// Imm_o: short immediate or second word
// Mem_ref_o: word carries a memory operand
// Fields are latched for every first word taken;
// Only those meaningful for the code matter.
// Latching all of them keeps the mux small
// At the cost of toggling unused outputs.

// ==========================================================
// Decode priority
// Full words are matched first, since
// Several of them share an upper byte with wider patterns.
// Narrow fixed prefixes come next:
// Compare, shift mode, pointer, page, multiply.
// The XOR and long-aux openers follow, then the
// Aux nibble forms, which need bit 11 clear
// So they cannot swallow byte opcodes
// That share the same upper nibble.
// Byte opcodes are decoded last.
// Anything left reports the illegal code
// With a valid pulse, so the fetch side
// Always sees an answer for every word.

// ==========================================================
// Sequencing
// A one-word form answers on the same edge
// That takes it.
// A two-word form keeps its first-word
// Fields and stays silent for one word;
// The next taken word lands in imm_o and
// The valid pulse rises together with it.
// Gaps in word_valid_i are allowed anywhere,
// Including between the two words of a pair.
// The decoder never stalls the fetch side,
// So word_ready_o is tied high.
// Limitation: a pair cannot be aborted;
// Only reset returns the sequencer early.

// ==========================================================
// Hazards
// Outputs other than op_valid_o hold until
// The next taken word, so the datapath must
// Act on the pulse, not on a level.
// The first word of a pair updates the
// Fields at once; consumers must wait for
// The pulse before using them.
// The op_code_o may show an opener's code
// While the pair is still open.

module adec_decoder #(
    parameter WORD_W = 16 // Instruction word width
) (
    input wire ref_clk_i, // Core clock
    input wire rstn_i, // Async reset, active low
    input wire word_valid_i, // Fetched word present
    input wire [WORD_W-1:0] word_i, // Fetched word
    output wire word_ready_o, // Decoder accepts a word
    output reg op_valid_o, // One-cycle pulse, controls valid
    output reg [`ADEC_OPW-1:0] op_code_o, // Operation for datapath
    output reg indirect_o, // Indirect addressing via current aux
    output reg [6:0] direct_off_o, // Direct page offset
    output reg [7:0] ind_ctrl_o, // Low byte for indirect side effects
    output reg [2:0] aux_sel_o, // Aux register number
    output reg [1:0] cond_o, // Compare condition or shift mode
    output reg [3:0] shift_o, // Immediate shift count
    output reg [15:0] imm_o, // Immediate or second word
    output reg mem_ref_o // Operation references data memory
);

    // ==========================================================
    // State
    reg state_q; // Waiting for first or second word
    reg [WORD_W-1:0] first_q; // Held first word of a pair
    reg [`ADEC_OPW-1:0] dec_op; // Combinational op of current word
    reg dec_mem; // Word uses the memory operand field
    reg dec_two; // Word needs a second word
    reg [15:0] dec_imm; // Immediate from first word

    wire [7:0] hi8 = word_i[15:8]; // Upper byte
    wire [3:0] hi4 = word_i[15:12]; // Upper nibble

    // Always ready: the second word is simply the next fetched word
    assign word_ready_o = 1'b1;

    // ==========================================================
    // Classify a single word; full-word matches tested first
    always @* begin
        dec_op = `ADEC_ILLEGAL;
        dec_mem = 1'b0;
        dec_two = 1'b0;
        dec_imm = 16'h0000;
        if (word_i == `ADEC_W_CLR_ACC) begin
            dec_op = `ADEC_CLR_ACC;
        end else if (word_i == `ADEC_W_ADD_PROD) begin
            dec_op = `ADEC_PROD_ADD;
        end else if (word_i == `ADEC_W_COPY_PROD) begin
            dec_op = `ADEC_PROD_COPY;
        end else if (word_i == `ADEC_W_SUB_PROD) begin
            dec_op = `ADEC_PROD_SUB;
        end else if (word_i[15:2] == `ADEC_P_CMP_HI14) begin
            dec_op = `ADEC_AUX_CMP;
        end else if (word_i[15:2] == `ADEC_P_PSHIFT_HI14) begin
            dec_op = `ADEC_SHIFT_MODE;
        end else if (word_i[15:3] == `ADEC_P_ARP_HI13) begin
            dec_op = `ADEC_AUX_PTR_LD;
            dec_imm = {13'h0000, word_i[2:0]};
        end else if (word_i[15:9] == `ADEC_P_PAGE_IMM_HI7) begin
            dec_op = `ADEC_PAGE_LD_IMM;
            dec_imm = {7'h00, word_i[8:0]};
        end else if (word_i[15:13] == `ADEC_P_MUL_IMM_HI3) begin
            dec_op = `ADEC_MUL_IMM;
            dec_imm = {{3{word_i[12]}}, word_i[12:0]};
        end else if (hi4 == `ADEC_P_XOR_IMM_HI4 && word_i[7:0] == `ADEC_P_XOR_IMM_LO) begin
            dec_op = `ADEC_XOR_IMM;
            dec_two = 1'b1;
        end else if (hi4 == `ADEC_N_AUX_LD_LONG && !word_i[11]
                     && word_i[7:0] == `ADEC_P_AUX_LONG_LO) begin
            dec_op = `ADEC_AUX_LD_LONG;
            dec_two = 1'b1;
        end else if (hi4 == `ADEC_N_AUX_LD_IMM && !word_i[11]) begin
            dec_op = `ADEC_AUX_LD_IMM;
            dec_imm = {8'h00, word_i[7:0]};
        end else if (hi4 == `ADEC_N_AUX_LD_MEM && !word_i[11]) begin
            dec_op = `ADEC_AUX_LD_MEM;
            dec_mem = 1'b1;
        end else if (hi4 == `ADEC_N_AUX_STORE && !word_i[11]) begin
            dec_op = `ADEC_AUX_STORE;
            dec_mem = 1'b1;
        end else begin
            dec_mem = 1'b1;
            case (hi8)
                `ADEC_OP_SUB_TSHIFT: dec_op = `ADEC_SUB_TSHIFT;
                `ADEC_OP_AUX_ADD: begin
                    dec_op = `ADEC_AUX_ADD;
                    dec_mem = 1'b0;
                    dec_imm = {8'h00, word_i[7:0]};
                end
                `ADEC_OP_AUX_SUB: begin
                    dec_op = `ADEC_AUX_SUB;
                    dec_mem = 1'b0;
                    dec_imm = {8'h00, word_i[7:0]};
                end
                `ADEC_OP_XOR_MEM: dec_op = `ADEC_XOR_MEM;
                `ADEC_OP_CLR_LD_HI: dec_op = `ADEC_CLR_LD_HI;
                `ADEC_OP_CLR_LD_LO: dec_op = `ADEC_CLR_LD_LO;
                `ADEC_OP_CLR_LD_RND: dec_op = `ADEC_CLR_LD_RND;
                `ADEC_OP_PAGE_MEM: dec_op = `ADEC_PAGE_LD_MEM;
                `ADEC_OP_AUX_MOD: dec_op = `ADEC_AUX_MODIFY;
                `ADEC_OP_PROD_HI_LD: dec_op = `ADEC_PROD_HI_LD;
                `ADEC_OP_PROD_HI_ST: dec_op = `ADEC_PROD_HI_ST;
                `ADEC_OP_PROD_LO_ST: dec_op = `ADEC_PROD_LO_ST;
                `ADEC_OP_TLOAD: dec_op = `ADEC_TLOAD;
                `ADEC_OP_TLOAD_ADD: dec_op = `ADEC_TLOAD_ADD;
                `ADEC_OP_TLOAD_MOVE: dec_op = `ADEC_TLOAD_MOVE;
                `ADEC_OP_TLOAD_COPY: dec_op = `ADEC_TLOAD_COPY;
                `ADEC_OP_TLOAD_SUB: dec_op = `ADEC_TLOAD_SUB;
                `ADEC_OP_MUL: dec_op = `ADEC_MUL;
                `ADEC_OP_MUL_ADD: dec_op = `ADEC_MUL_ADD;
                `ADEC_OP_MUL_SUB: dec_op = `ADEC_MUL_SUB;
                `ADEC_OP_MUL_UNS: dec_op = `ADEC_MUL_UNS;
                `ADEC_OP_SQR_ADD: dec_op = `ADEC_SQR_ADD;
                `ADEC_OP_SQR_SUB: dec_op = `ADEC_SQR_SUB;
                `ADEC_OP_MAC: begin
                    dec_op = `ADEC_MAC;
                    dec_two = 1'b1;
                end
                `ADEC_OP_MAC_MOVE: begin
                    dec_op = `ADEC_MAC_MOVE;
                    dec_two = 1'b1;
                end
                default: begin
                    dec_mem = 1'b0; // Not ours: flagged illegal
                end
            endcase
        end
    end

    // ==========================================================
    // Sequencer and registered controls
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= `ADEC_ST_FIRST;
            first_q <= 16'h0000;
            op_valid_o <= 1'b0;
            op_code_o <= `ADEC_NOP;
            indirect_o <= 1'b0;
            direct_off_o <= 7'h00;
            ind_ctrl_o <= 8'h00;
            aux_sel_o <= 3'h0;
            cond_o <= 2'h0;
            shift_o <= 4'h0;
            imm_o <= 16'h0000;
            mem_ref_o <= 1'b0;
        end else begin
            op_valid_o <= 1'b0;
            if (word_valid_i) begin
                case (state_q)
                    `ADEC_ST_FIRST: begin
                        op_code_o <= dec_op;
                        mem_ref_o <= dec_mem;
                        indirect_o <= dec_mem & word_i[7];
                        direct_off_o <= word_i[6:0];
                        ind_ctrl_o <= word_i[7:0];
                        aux_sel_o <= word_i[10:8];
                        cond_o <= word_i[1:0];
                        shift_o <= word_i[11:8];
                        imm_o <= dec_imm;
                        if (dec_two) begin
                            first_q <= word_i;
                            state_q <= `ADEC_ST_SECOND;
                        end else begin
                            op_valid_o <= 1'b1;
                        end
                    end
                    `ADEC_ST_SECOND: begin
                        imm_o <= word_i;
                        op_valid_o <= 1'b1;
                        state_q <= `ADEC_ST_FIRST;
                    end
                    default: begin
                        state_q <= `ADEC_ST_FIRST;
                    end
                endcase
            end
        end
    end

endmodule // adec_decoder

/* daad_fetch_model.sv */
// Purpose: Fetch-side model feeding instruction words
// Assumes: Words launch just after a rising edge
// Notes: Idle bus shows the inverse of the last word
`timescale 1ns/1ps
// ============================================
// Fetch model
module daad_fetch_model (
    input wire ref_clk_i, // Core clock
    output logic word_valid_o, // Word present
    output logic [15:0] word_o // Fetched word
);
    // Quiet bus at time zero
    initial begin
        word_valid_o = 1'b0;
        word_o = 16'h0000;
    end
    // Offer a word; #1 lets the edge's updates land
    task push(input logic [15:0] w);
        @(posedge ref_clk_i);
        word_valid_o <= 1'b1;
        word_o <= w;
        #1;
    endtask
    // Release; inverted data so a stale word never looks current
    task idle();
        @(posedge ref_clk_i);
        word_valid_o <= 1'b0;
        word_o <= ~word_o;
        #1;
    endtask
endmodule // daad_fetch_model

/* daad_decoder_sva.sv */
// Purpose: Port assertions for the arithmetic/aux decoder
// Assumes: One clock, async active-low reset
// Notes: A helper flag tracks two-word pairs
`timescale 1ns/1ps
// ============================================
// Checker
module daad_decoder_sva (
    input wire ref_clk_i, // Core clock
    input wire rstn_i, // Reset, active low
    input wire word_valid_i, // Word offered
    input wire [15:0] word_i, // Offered word
    input wire op_valid_o, // Controls valid
    input wire [5:0] op_code_o, // Operation code
    input wire indirect_o, // Indirect flag
    input wire [6:0] direct_off_o, // Direct offset
    input wire [2:0] aux_sel_o, // Aux number
    input wire [1:0] cond_o, // Condition or mode
    input wire [15:0] imm_o // Immediate
);
    logic pend_q; // Waiting for a second word
    logic pend_d; // Next pending state
    wire first_w = (word_i[15:12] == 4'hD && word_i[7:0] == 8'h06) ||
        (word_i[15:11] == 5'h1A && word_i[7:0] == 8'h00) || word_i[15:9] == 7'h2E; // Openers
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Second word is operand, never an opcode
    assign pend_d = word_valid_i ? (!pend_q && first_w) : pend_q;
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) pend_q <= 1'b0;
        else pend_q <= pend_d;
    end
    sequence s_take(hit); word_valid_i && !pend_q && !first_w && hit; endsequence
    sequence s_open; word_valid_i && !pend_q && first_w; endsequence
    sequence s_second; word_valid_i && pend_q; endsequence
    a_clr_code: assert property (s_take(word_i == 16'hCA00) |=> op_code_o == 6'h04)
        else $error("bad clear code");
    a_prod_add: assert property (s_take(word_i == 16'hCE15) |=> op_code_o == 6'h12)
        else $error("bad product add code");
    a_aux_imm: assert property (s_take(word_i[15:8] == 8'h7E) |=> imm_o[7:0] == $past(word_i[7:0]))
        else $error("bad aux immediate");
    a_cmp_cond: assert property (s_take(word_i[15:2] == 14'h3394) |=> cond_o == $past(word_i[1:0]))
        else $error("bad compare condition");
    a_aux_sel: assert property (s_take(word_i[15:11] == 5'h06) |=> aux_sel_o == $past(word_i[10:8]))
        else $error("bad aux number");
    a_mul_sext: assert property (s_take(word_i[15:13] == 3'h5) |=> imm_o[15:12] == {4{$past(word_i[12])}})
        else $error("bad immediate sign");
    a_mem_ind: assert property (s_take(word_i[15:8] == 8'h38) |=> indirect_o == $past(word_i[7]) &&
        direct_off_o == $past(word_i[6:0])) else $error("bad address mode");
    a_pair_wait: assert property (s_open |=> !op_valid_o)
        else $error("pair ended early");
    a_pair_done: assert property (s_second |=> op_valid_o && imm_o == $past(word_i))
        else $error("pair operand lost");
endmodule // daad_decoder_sva

/* dsp_arith_aux_decoder_bench.sv */
// Purpose: Self-checking bench for the arithmetic/aux decoder
// Assumes: Fetch model drives the word port
// Notes: Expected codes follow the decoder's own code choices
`timescale 1ns/1ps
// ============================================
// Bench top
module dsp_arith_aux_decoder_bench;
    logic ref_clk_i; // Core clock
    logic rstn_i; // Reset, active low
    wire word_valid, ready, op_valid, indirect, mem_ref; // Strobes
    wire [15:0] word, imm; // Word in, immediate out
    wire [5:0] op_code; // Operation code
    wire [6:0] direct_off; // Direct offset
    wire [7:0] ind_ctrl; // Indirect field
    wire [2:0] aux_sel; // Aux number
    wire [1:0] cond; // Condition or mode
    wire [3:0] shift; // Immediate shift
    int error_cnt = 0; // Mismatches
    int total_checks = 0; // Comparisons
    // {op, word}, issued back to back
    logic [21:0] op_tbl [0:35] = '{22'h014623, 22'h024C85, 22'h04CA00, 22'h054012,
        22'h064112, 22'h077B12, 22'h087E12, 22'h097F12, 22'h0ACE52, 22'h0B3312, 22'h0C7412,
        22'h0DC512, 22'h0F558D, 22'h105288, 22'h11C912, 22'h12CE15, 22'h13CE14, 22'h14CE16,
        22'h153C12, 22'h163D12, 22'h173F12, 22'h183E12, 22'h195B12, 22'h1A3812, 22'h1B3A12,
        22'h1C3B12, 22'h1DCF12, 22'h1EA123, 22'h213912, 22'h225A12, 22'h23CE09, 22'h245312,
        22'h257D12, 22'h267C12, 22'h275512, 22'h3FE000};
    // {op, first, second}
    logic [37:0] pair_tbl [0:3] = '{38'h03D1061234, 38'h0ED300ABCD, 38'h1F5D125555,
        38'h205C800F0F};
    adec_decoder i_adec_decoder (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .word_valid_i(word_valid),
        .word_i(word), .word_ready_o(ready), .op_valid_o(op_valid), .op_code_o(op_code),
        .indirect_o(indirect), .direct_off_o(direct_off), .ind_ctrl_o(ind_ctrl),
        .aux_sel_o(aux_sel), .cond_o(cond), .shift_o(shift), .imm_o(imm), .mem_ref_o(mem_ref));
    daad_fetch_model i_daad_fetch_model (.ref_clk_i(ref_clk_i), .word_valid_o(word_valid),
        .word_o(word));
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task summarize();
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One word, then release so its controls settle
    task send1(input logic [15:0] w);
        i_daad_fetch_model.push(w);
        i_daad_fetch_model.idle();
    endtask
    // Every one-word code back to back; each result lands one edge later
    task t_opcodes();
        for (int i = 0; i <= 36; i++) begin
            if (i < 36) i_daad_fetch_model.push(op_tbl[i][15:0]);
            else i_daad_fetch_model.idle();
            if (i > 0) begin
                check("op_code", op_code, op_tbl[i-1][21:16]);
                check("op_valid", op_valid, 1'h1);
            end
        end
    endtask
    // Operand fields, with boundary values
    task t_fields();
        send1(16'h38FF);
        check("indirect", indirect, 1'h1);
        check("ind_ctrl", ind_ctrl, 8'hFF);
        send1(16'h3805);
        check("direct_off", {indirect, direct_off}, 8'h05);
        check("mem_ref", mem_ref, 1'h1);
        send1(16'hBFFF);
        check("imm", imm, 16'hFFFF);
        send1(16'hC9FF);
        check("imm", imm, 16'h01FF);
        send1(16'h7EFF);
        check("imm", imm, 16'h00FF);
        check("mem_ref", mem_ref, 1'h0);
        send1(16'hCE53);
        check("cond", cond, 2'h3);
        send1(16'hCE0A);
        check("cond", cond, 2'h2);
        send1(16'h558F);
        check("imm", imm[2:0], 3'h7);
        send1(16'h3712);
        check("aux_sel", aux_sel, 3'h7);
    endtask
    // Two-word forms: silent after the first word, pulse after the second
    task t_pairs();
        for (int i = 0; i < 4; i++) begin
            i_daad_fetch_model.push(pair_tbl[i][31:16]);
            i_daad_fetch_model.push(pair_tbl[i][15:0]);
            check("op_valid", op_valid, 1'h0);
            i_daad_fetch_model.idle();
            check("op_valid", op_valid, 1'h1);
            check("op_code", op_code, pair_tbl[i][37:32]);
            check("imm", imm, pair_tbl[i][15:0]);
            if (i == 0) check("shift", shift, 4'h1);
            if (i == 1) check("aux_sel", aux_sel, 3'h3);
        end
        i_daad_fetch_model.idle();
        check("op_valid", op_valid, 1'h0);
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Watchdog: whole run is under a hundred cycles
    initial begin
        #20000;
        error_cnt++;
        summarize();
    end
    initial begin
        rstn_i = 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        @(posedge ref_clk_i);
        #1;
        check("reset op_code", {ready, op_valid, op_code}, 8'h80);
        t_opcodes();
        t_fields();
        t_pairs();
        summarize();
    end
endmodule // dsp_arith_aux_decoder_bench
bind adec_decoder daad_decoder_sva i_daad_decoder_sva (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .word_valid_i(word_valid_i), .word_i(word_i), .op_valid_o(op_valid_o), .op_code_o(op_code_o),
    .indirect_o(indirect_o), .direct_off_o(direct_off_o), .aux_sel_o(aux_sel_o), .cond_o(cond_o),
    .imm_o(imm_o));
